/* File: rtl/pvc_regs.svh */
// register map, field positions and reset values of the counter/strap bank
`ifndef PVC_REGS_SVH
`define PVC_REGS_SVH

// register indices; byte address is four times the index
`define PVC_IDX_SPEC_CFG 8'h14
`define PVC_IDX_RX_ERR 8'h16
`define PVC_IDX_DISC 8'h17
`define PVC_IDX_STRAP 8'h18
`define PVC_IDX_PWR_SAVE 8'h1D
`define PVC_IDX_IRQ_STAT 8'h1E
`define PVC_IDX_IRQ_MASK 8'h1F

// specified-configuration fields
`define PVC_CFG_PREAMBLE 11
`define PVC_CFG_TX10M 10
`define PVC_CFG_MASK 16'h0C00
`define PVC_CFG_RESET 16'h0000

// power saving control fields
`define PVC_PSC_TRIM 11
`define PVC_PSC_AMP 10
`define PVC_PSC_DRV 9
`define PVC_PSC_MASK 16'h0E00
`define PVC_PSC_RESET 16'h0000

// strap snapshot fields
`define PVC_STRAP_LED_STYLE 15
`define PVC_STRAP_IRQ_PIN 14
`define PVC_STRAP_CABLE 13
`define PVC_STRAP_ISOLATE 12
`define PVC_STRAP_RMII 11
`define PVC_STRAP_SERIAL 10
`define PVC_STRAP_REPEATER 9
`define PVC_STRAP_TEST 8
`define PVC_STRAP_OP_HI 7
`define PVC_STRAP_OP_LO 5
`define PVC_STRAP_ADDR_HI 4
`define PVC_STRAP_ADDR_LO 0
`define PVC_STRAP_RESET 16'hC4E0

// counters
`define PVC_RX_ERR_RESET 16'h0000
`define PVC_DISC_RESET 8'h00
`define PVC_DISC_PAD 8'h00

// interrupt status and mask
`define PVC_IRQ_RX_ERR 0
`define PVC_IRQ_DISC 1
`define PVC_IRQ_RESET 2'h0

// preamble bits removed
`define PVC_TRIM_NONE 5'h00
`define PVC_TRIM_SHORT 5'h0A
`define PVC_TRIM_LONG 5'h14

`define PVC_DATA_PAD 16'h0000
`define PVC_RD_ZERO 16'h0000

`endif

/* File: rtl/pvc_pkg.sv */
// types shared by the counter/strap register bank
package pvc_pkg;
  typedef enum logic [0:0] {
    PVC_ST_CAPTURE = 1'b0,
    PVC_ST_RUN = 1'b1
  } pvc_state_t;
endpackage

/* File: rtl/pvc_regs_top.sv */
// counter, strap snapshot and power saving registers behind Wishbone
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
`include "pvc_regs.svh"

module pvc_regs_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // events from the datapath, same clock
  input wire logic rx_err_i,
  input wire logic link_up_i,
  // strap pins, asynchronous
  input wire logic led_style_strap_pin_i,
  input wire logic mgmt_irq_pin_i,
  input wire logic cable_state_pin_i,
  input wire logic tx_clk_pin_i,
  input wire logic col_pin_i,
  input wire logic rx_clk_pin_i,
  input wire logic rx_er_pin_i,
  input wire logic rx_dv_pin_i,
  input wire logic [2:0] indicator_pin_i,
  input wire logic crs_pin_i,
  input wire logic [3:0] rxd_pin_i,
  // transmitter controls
  output logic [4:0] preamble_trim_bits_o,
  output logic tx_amp_reduce_o,
  output logic tx_drive_reduce_o,
  output logic tx_10m_saving_o,
  // interrupt
  output logic irq_o
);

  pvc_pkg::pvc_state_t state_reg;
  logic [15:0] strap_raw;
  logic [15:0] strap_meta_reg;
  logic [15:0] strap_sync_reg;
  logic [15:0] strap_reg;
  logic [15:0] rx_err_cnt_reg;
  logic [7:0] disc_cnt_reg;
  logic [15:0] spec_cfg_reg;
  logic [15:0] pwr_save_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  logic [1:0] irq_stat_next;
  logic [1:0] irq_events;
  logic [1:0] irq_w1c;
  logic rx_err_d_reg;
  logic link_d_reg;
  logic rx_err_evt;
  logic disc_evt;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic access;
  logic rd_strobe;
  logic wr_strobe;
  logic [7:0] idx;
  logic [15:0] wr_lanes;
  logic [15:0] rd_data;
  logic [4:0] trim_reg;
  logic amp_reg;
  logic drive_reg;
  logic saving_reg;
  logic irq_reg;

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign preamble_trim_bits_o = trim_reg;
  assign tx_amp_reduce_o = amp_reg;
  assign tx_drive_reduce_o = drive_reg;
  assign tx_10m_saving_o = saving_reg;
  assign irq_o = irq_reg;

  // strap pins in snapshot bit order
  assign strap_raw = {
    led_style_strap_pin_i,
    mgmt_irq_pin_i,
    cable_state_pin_i,
    tx_clk_pin_i,
    col_pin_i,
    rx_clk_pin_i,
    rx_er_pin_i,
    rx_dv_pin_i,
    indicator_pin_i,
    crs_pin_i,
    rxd_pin_i
  };

  // two-stage synchroniser per strap pin, running through reset
  for (genvar g = 0; g < 16; g++) begin : g_strap_sync
    always_ff @(posedge clk_i) begin
      strap_meta_reg[g] <= strap_raw[g];
      strap_sync_reg[g] <= strap_meta_reg[g];
    end
  end

  // one capture cycle after reset release, then normal operation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= pvc_pkg::PVC_ST_CAPTURE;
    end else begin
      unique case (state_reg)
        pvc_pkg::PVC_ST_CAPTURE: state_reg <= pvc_pkg::PVC_ST_RUN;
        pvc_pkg::PVC_ST_RUN: state_reg <= pvc_pkg::PVC_ST_RUN;
      endcase
    end
  end

  // strap snapshot: defaults in reset, pin levels caught on release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_reg <= `PVC_STRAP_RESET;
    end else if (state_reg == pvc_pkg::PVC_ST_CAPTURE) begin
      strap_reg[`PVC_STRAP_LED_STYLE] <=
        strap_sync_reg[`PVC_STRAP_LED_STYLE];
      strap_reg[`PVC_STRAP_IRQ_PIN] <=
        strap_sync_reg[`PVC_STRAP_IRQ_PIN];
      strap_reg[`PVC_STRAP_CABLE] <=
        strap_sync_reg[`PVC_STRAP_CABLE];
      strap_reg[`PVC_STRAP_ISOLATE] <=
        strap_sync_reg[`PVC_STRAP_ISOLATE];
      strap_reg[`PVC_STRAP_RMII] <=
        strap_sync_reg[`PVC_STRAP_RMII];
      strap_reg[`PVC_STRAP_SERIAL] <=
        strap_sync_reg[`PVC_STRAP_SERIAL];
      strap_reg[`PVC_STRAP_REPEATER] <=
        strap_sync_reg[`PVC_STRAP_REPEATER];
      strap_reg[`PVC_STRAP_TEST] <=
        strap_sync_reg[`PVC_STRAP_TEST];
      strap_reg[`PVC_STRAP_OP_HI:`PVC_STRAP_OP_LO] <=
        strap_sync_reg[`PVC_STRAP_OP_HI:`PVC_STRAP_OP_LO];
      strap_reg[`PVC_STRAP_ADDR_HI:`PVC_STRAP_ADDR_LO] <=
        strap_sync_reg[`PVC_STRAP_ADDR_HI:`PVC_STRAP_ADDR_LO];
    end
  end

  // bus decode; requests wait until the straps are caught
  assign access = wb_cyc_i & wb_stb_i & ~ack_reg &
                  (state_reg == pvc_pkg::PVC_ST_RUN);
  assign rd_strobe = access & ~wb_we_i;
  assign wr_strobe = access & wb_we_i;
  assign idx = wb_adr_i[9:2];

  // byte lanes merge over a zero base; only masked bits are kept
  always_comb begin
    wr_lanes = `PVC_DATA_PAD;
    if (wb_sel_i[0]) begin
      wr_lanes[7:0] = wb_dat_i[7:0];
    end
    if (wb_sel_i[1]) begin
      wr_lanes[15:8] = wb_dat_i[15:8];
    end
  end

  // read mux; unmapped indices read zero
  always_comb begin
    case (idx)
      `PVC_IDX_SPEC_CFG: rd_data = spec_cfg_reg;
      `PVC_IDX_RX_ERR: rd_data = rx_err_cnt_reg;
      `PVC_IDX_DISC: rd_data = {`PVC_DISC_PAD, disc_cnt_reg};
      `PVC_IDX_STRAP: rd_data = strap_reg;
      `PVC_IDX_PWR_SAVE: rd_data = pwr_save_reg;
      `PVC_IDX_IRQ_STAT: rd_data = 16'(irq_stat_reg);
      `PVC_IDX_IRQ_MASK: rd_data = 16'(irq_mask_reg);
      default: rd_data = `PVC_RD_ZERO;
    endcase
  end

  // answer one cycle after the request, for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= access;
      if (rd_strobe) begin
        dat_reg <= {`PVC_DATA_PAD, rd_data};
      end
    end
  end

  // event detection from the datapath
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_err_d_reg <= 1'b0;
      link_d_reg <= 1'b0;
    end else begin
      rx_err_d_reg <= rx_err_i;
      link_d_reg <= link_up_i;
    end
  end

  assign rx_err_evt = rx_err_i & ~rx_err_d_reg;
  assign disc_evt = link_d_reg & ~link_up_i;

  // receive error tally; an error in the clearing read's cycle counts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_err_cnt_reg <= `PVC_RX_ERR_RESET;
    end else if (rd_strobe && idx == `PVC_IDX_RX_ERR) begin
      rx_err_cnt_reg <= 16'(rx_err_evt);
    end else if (rx_err_evt) begin
      rx_err_cnt_reg <= rx_err_cnt_reg + 16'h0001;
    end
  end

  // disconnect tally, same clearing behaviour
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      disc_cnt_reg <= `PVC_DISC_RESET;
    end else if (rd_strobe && idx == `PVC_IDX_DISC) begin
      disc_cnt_reg <= 8'(disc_evt);
    end else if (disc_evt) begin
      disc_cnt_reg <= disc_cnt_reg + 8'h01;
    end
  end

  // writable control registers; writes to read-only or unmapped indices are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spec_cfg_reg <= `PVC_CFG_RESET;
    end else if (wr_strobe && idx == `PVC_IDX_SPEC_CFG) begin
      spec_cfg_reg <= (spec_cfg_reg & ~(`PVC_CFG_MASK & {
                        {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}})) |
                      (wr_lanes & `PVC_CFG_MASK);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_save_reg <= `PVC_PSC_RESET;
    end else if (wr_strobe && idx == `PVC_IDX_PWR_SAVE) begin
      pwr_save_reg <= (pwr_save_reg & ~(`PVC_PSC_MASK & {
                        {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}})) |
                      (wr_lanes & `PVC_PSC_MASK);
    end
  end

  // transmitter power saving outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trim_reg <= `PVC_TRIM_NONE;
      amp_reg <= 1'b0;
      drive_reg <= 1'b0;
      saving_reg <= 1'b0;
    end else begin
      if (!spec_cfg_reg[`PVC_CFG_TX10M] &&
          spec_cfg_reg[`PVC_CFG_PREAMBLE]) begin
        trim_reg <= pwr_save_reg[`PVC_PSC_TRIM] ?
                    `PVC_TRIM_SHORT : `PVC_TRIM_LONG;
      end else begin
        trim_reg <= `PVC_TRIM_NONE;
      end
      amp_reg <= ~pwr_save_reg[`PVC_PSC_AMP] & ~link_up_i;
      drive_reg <= ~pwr_save_reg[`PVC_PSC_DRV] & ~link_up_i;
      saving_reg <= spec_cfg_reg[`PVC_CFG_TX10M];
    end
  end

  // sticky event flags, write one to clear, a new event wins
  always_comb begin
    irq_events = '0;
    irq_events[`PVC_IRQ_RX_ERR] = rx_err_evt;
    irq_events[`PVC_IRQ_DISC] = disc_evt;
    irq_w1c = '0;
    if (wr_strobe && idx == `PVC_IDX_IRQ_STAT && wb_sel_i[0]) begin
      irq_w1c = wb_dat_i[1:0];
    end
    irq_stat_next = (irq_stat_reg & ~irq_w1c) | irq_events;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= `PVC_IRQ_RESET;
    end else begin
      irq_stat_reg <= irq_stat_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_reg <= `PVC_IRQ_RESET;
    end else if (wr_strobe && idx == `PVC_IDX_IRQ_MASK && wb_sel_i[0]) begin
      irq_mask_reg <= wb_dat_i[1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

endmodule

/* File: verif/pvc_regs_checker.sv */
// port assertions for the counter/strap register bank
`timescale 1ns/1ps
`include "pvc_regs.svh"
module pvc_regs_checker (
  // watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic link_up_i,
  input wire logic [4:0] preamble_trim_bits_o,
  input wire logic tx_amp_reduce_o,
  input wire logic tx_drive_reduce_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  upper_zero_a: assert property (
    wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read data not zero");
  disc_upper_a: assert property (
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i[9:2]) == `PVC_IDX_DISC
    |-> wb_dat_o[15:8] == 8'h00)
    else $error("disconnect upper byte not zero");
  psc_rsvd_a: assert property (
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i[9:2]) == `PVC_IDX_PWR_SAVE
    |-> wb_dat_o[15:12] == 4'h0 && wb_dat_o[8:0] == 9'h000)
    else $error("power save reserved bits set");
  unmapped_zero_a: assert property (
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i[9:2]) > 8'h1F
    |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  trim_value_a: assert property (
    preamble_trim_bits_o inside {5'h00, 5'h0A, 5'h14})
    else $error("bad preamble trim amount");
  amp_link_a: assert property ($past(link_up_i) |-> !tx_amp_reduce_o)
    else $error("amplitude reduced with link up");
  drive_link_a: assert property (
    $past(link_up_i) |-> !tx_drive_reduce_o)
    else $error("drive reduced with link up");
endmodule

bind pvc_regs_top pvc_regs_checker pvc_regs_checker_inst (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
  .link_up_i, .preamble_trim_bits_o, .tx_amp_reduce_o, .tx_drive_reduce_o);

/* File: verif/pvc_wb_master.sv */
// station management side: classic wishbone master
`timescale 1ns/1ps
module pvc_wb_master (
  // clock and answer
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  // request
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [9:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  initial begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  end
  // waits for ack as long as it takes; only the bench timeout ends a hang
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [3:0] s, input logic [15:0] wd,
                      output logic [31:0] rd);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o} <= {2'b11, w};
    adr_o <= {idx, 2'b00};
    sel_o <= s;
    dat_o <= {16'h0000, wd};
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    rd = dat_i;
    {cyc_o, stb_o, we_o} <= 3'b000;
    // released data bus must not keep looking valid
    dat_o <= ~{16'h0000, wd};
  endtask
endmodule

/* File: verif/pvc_regs_top_tb.sv */
// self-checking bench for the counter/strap register bank
`timescale 1ns/1ps
module pvc_regs_top_tb;
  typedef struct {logic w; logic [7:0] i; logic [15:0] d, e;} pvc_row_t;
  logic clk_i, rst_i, rx_err_i, link_up_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic wb_ack_o, tx_amp_reduce_o, tx_drive_reduce_o, tx_10m_saving_o, irq_o;
  logic [9:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [15:0] straps;
  logic [3:0] lanes;
  logic [4:0] preamble_trim_bits_o;
  int num_errors, checked, cyc_n;
  pvc_row_t rows[18] = '{
    '{0,8'h14,0,16'h0000}, '{0,8'h1D,0,16'h0000}, '{0,8'h1E,0,16'h0000},
    '{0,8'h1F,0,16'h0000}, '{0,8'h16,0,16'h0000}, '{0,8'h17,0,16'h0000},
    '{0,8'h18,0,16'h6A55}, '{1,8'h18,16'hFFFF,0}, '{0,8'h18,0,16'h6A55},
    '{1,8'h16,16'hFFFF,0}, '{0,8'h16,0,16'h0000}, '{1,8'h17,16'hFFFF,0},
    '{0,8'h17,0,16'h0000}, '{1,8'h20,16'hFFFF,0}, '{0,8'h20,0,16'h0000},
    '{1,8'h14,16'hFFFF,0}, '{0,8'h14,0,16'h0C00}, '{1,8'h1D,16'hFFFF,0}};
  pvc_regs_top pvc_regs_top_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .rx_err_i, .link_up_i, .led_style_strap_pin_i(straps[15]),
    .mgmt_irq_pin_i(straps[14]), .cable_state_pin_i(straps[13]),
    .tx_clk_pin_i(straps[12]), .col_pin_i(straps[11]),
    .rx_clk_pin_i(straps[10]), .rx_er_pin_i(straps[9]),
    .rx_dv_pin_i(straps[8]), .indicator_pin_i(straps[7:5]),
    .crs_pin_i(straps[4]), .rxd_pin_i(straps[3:0]), .preamble_trim_bits_o,
    .tx_amp_reduce_o, .tx_drive_reduce_o, .tx_10m_saving_o, .irq_o);
  pvc_wb_master pvc_wb_master_inst (.clk_i, .ack_i(wb_ack_o),
    .dat_i(wb_dat_o), .cyc_o(wb_cyc_i), .stb_o(wb_stb_i), .we_o(wb_we_i),
    .adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task summarize;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] i, input logic [15:0] d);
    pvc_wb_master_inst.xfer(1'b1, i, lanes, d, rd);
  endtask
  task rdc(input string n, input logic [7:0] i, input logic [15:0] e);
    pvc_wb_master_inst.xfer(1'b0, i, 4'h3, 16'h0000, rd);
    chk(n, {16'h0000, e}, rd);
  endtask
  // straps stay put through reset and capture, then move
  task do_reset(input logic [15:0] p);
    @(posedge clk_i);
    straps <= p;
    rst_i <= 1'b1;
    repeat (7) @(posedge clk_i);
    @(negedge clk_i);
    chk("rst_dat", 32'h0000_0000, wb_dat_o);
    chk("rst_out", 32'h0000_0000, {wb_ack_o, irq_o, tx_amp_reduce_o,
        tx_drive_reduce_o, tx_10m_saving_o, preamble_trim_bits_o});
    @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    straps <= ~p;
  endtask
  task pulse(input int n, input bit disc);
    repeat (n) begin
      @(posedge clk_i);
      if (disc) link_up_i <= 1'b1;
      else rx_err_i <= 1'b1;
      @(posedge clk_i);
      {rx_err_i, link_up_i} <= 2'b00;
    end
  endtask
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 5000) begin
      num_errors++;
      summarize;
    end
  end
  initial begin
    {num_errors, checked, cyc_n} = '0;
    {rx_err_i, link_up_i} = 2'b00;
    rst_i = 1'b1;
    lanes = 4'h3;
    do_reset(16'h6A55);
    foreach (rows[k]) begin
      if (rows[k].w) wr(rows[k].i, rows[k].d);
      else rdc("reg_row", rows[k].i, rows[k].e);
    end
    rdc("psc_rw", 8'h1D, 16'h0E00);
    // byte lanes: only the enabled lane of a write may land
    lanes = 4'h1;
    wr(8'h1D, 16'h0000);
    rdc("psc_lane0", 8'h1D, 16'h0E00);
    lanes = 4'h2;
    wr(8'h1D, 16'h0000);
    rdc("psc_lane1", 8'h1D, 16'h0000);
    lanes = 4'h3;
    for (int k = 0; k < 8; k++) begin
      wr(8'h14, {4'h0, k[1], k[0], 10'h000});
      wr(8'h1D, {4'h0, k[2], k[0], k[1], 9'h000});
      repeat (2) @(negedge clk_i);
      chk("trim", (!k[0] && k[1]) ? (k[2] ? 5'h0A : 5'h14) : 5'h00,
          preamble_trim_bits_o);
      chk("amp", !k[0], tx_amp_reduce_o);
      chk("drive", !k[1], tx_drive_reduce_o);
      chk("save10", k[0], tx_10m_saving_o);
    end
    wr(8'h1D, 16'h0000);
    pulse(3, 1'b0);
    rdc("rx_err", 8'h16, 16'h0003);
    rdc("rx_err_clr", 8'h16, 16'h0000);
    pulse(257, 1'b1);
    rdc("disc_wrap", 8'h17, 16'h0001);
    rdc("disc_clr", 8'h17, 16'h0000);
    wr(8'h1E, 16'h0003);
    pulse(1, 1'b0);
    repeat (2) @(negedge clk_i);
    chk("irq_masked", 32'h0, irq_o);
    rdc("irq_stat", 8'h1E, 16'h0001);
    wr(8'h1F, 16'h0001);
    repeat (2) @(negedge clk_i);
    chk("irq_on", 32'h1, irq_o);
    wr(8'h1E, 16'h0001);
    repeat (2) @(negedge clk_i);
    chk("irq_off", 32'h0, irq_o);
    do_reset(16'h95AA);
    rdc("strap_again", 8'h18, 16'h95AA);
    rdc("strap_same", 8'h18, 16'h95AA);
    rdc("cfg_again", 8'h14, 16'h0000);
    summarize;
  end
endmodule
